// ---- hw/clcr_pkg.sv ----
// Shared constants and state layout of the core-logic configuration bank
package clcr_pkg;

   // I/O port addresses of the index/data pair
   localparam logic [15:0] IO_INDEX_PORT = 16'h0024;
   localparam logic [15:0] IO_DATA_PORT  = 16'h0028;

   // Register indices
   localparam logic [7:0] IDX_DRAM_CAS   = 8'h0c;
   localparam logic [7:0] IDX_DRAM_WRITE = 8'h0d;
   localparam logic [7:0] IDX_L2_ONE     = 8'h10;
   localparam logic [7:0] IDX_L2_TWO     = 8'h11;
   localparam logic [7:0] IDX_L2_THREE   = 8'h12;
   localparam logic [7:0] IDX_PCI_ONE    = 8'h20;
   localparam logic [7:0] IDX_PCI_SLOT   = 8'h21;
   localparam logic [7:0] IDX_TOP_LOW    = 8'h22;
   localparam logic [7:0] IDX_PCI_TWO    = 8'h23;
   localparam logic [7:0] IDX_IDE_HW     = 8'h60;
   // Drive order: primary master, primary slave, secondary master, secondary slave
   localparam logic [3:0][7:0] IDX_IDE_SETUP    = {8'h70, 8'h6b, 8'h66, 8'h61};
   localparam logic [3:0][7:0] IDX_IDE_RECOVERY = {8'h71, 8'h6c, 8'h67, 8'h62};

   // Writable bit masks, reserved bits stay zero
   localparam logic [7:0] MASK_DRAM_CAS   = 8'hff;
   localparam logic [7:0] MASK_DRAM_WRITE = 8'hff;
   localparam logic [7:0] MASK_L2_ONE     = 8'hff;
   localparam logic [7:0] MASK_L2_TWO     = 8'hff;
   localparam logic [7:0] MASK_L2_THREE   = 8'he1;
   localparam logic [7:0] MASK_PCI_ONE    = 8'hfc;
   localparam logic [7:0] MASK_PCI_SLOT   = 8'hff;
   localparam logic [7:0] MASK_TOP_LOW    = 8'hff;
   localparam logic [7:0] MASK_PCI_TWO    = 8'hff;
   localparam logic [7:0] MASK_IDE_HW     = 8'hfe;
   localparam logic [7:0] MASK_SETUP_PM   = 8'hef;
   localparam logic [7:0] MASK_SETUP      = 8'h0f;
   localparam logic [7:0] MASK_RECOVERY   = 8'hff;

   // Reset values
   localparam logic [7:0] RST_DRAM_CAS   = 8'hfc;
   localparam logic [7:0] RST_DRAM_WRITE = 8'he3;
   localparam logic [7:0] RST_L2_ONE     = 8'h00;
   localparam logic [7:0] RST_L2_TWO     = 8'h00;
   localparam logic [7:0] RST_L2_THREE   = 8'h00;
   localparam logic [7:0] RST_PCI_ONE    = 8'hfc;
   localparam logic [7:0] RST_PCI_SLOT   = 8'h00;
   localparam logic [7:0] RST_TOP_LOW    = 8'h00;
   localparam logic [7:0] RST_PCI_TWO    = 8'he0;
   localparam logic [7:0] RST_IDE_HW     = 8'h00;
   localparam logic [7:0] RST_IDE_TIME   = 8'h00;

   // Timing figures
   localparam logic [3:0] SLOT_PRESCALE_LAST = 4'hf;   // Divide by 16
   localparam logic [4:0] IDE_CODE_ZERO_CLKS = 5'h10;  // Code 0 means 16 clocks
   localparam logic [1:0] IDE_CMD_OFF_SHORT  = 2'h2;
   localparam logic [1:0] IDE_CMD_OFF_LONG   = 2'h3;
   localparam logic [10:0] L2_SIZE_BASE_KB   = 11'h080;

   // Whole block state
   typedef struct packed {
      logic [7:0]      index;
      logic [7:0]      dram_cas;
      logic [7:0]      dram_write;
      logic [7:0]      l2_one;
      logic [7:0]      l2_two;
      logic [7:0]      l2_three;
      logic [7:0]      pci_one;
      logic [7:0]      pci_slot;
      logic [7:0]      top_low;
      logic [7:0]      pci_two;
      logic [7:0]      ide_hw;
      logic [3:0][7:0] ide_setup;
      logic [3:0][7:0] ide_recovery;
      logic [7:0]      rdata;
      logic [3:0]      prescale;
      logic [7:0]      slot_left;
      logic            slot_expired;
      logic            req_meta;
      logic            req_sync;
   } clcr_state_t;

   localparam clcr_state_t CLCR_STATE_RST = '{
      index:        8'h00,
      dram_cas:     RST_DRAM_CAS,
      dram_write:   RST_DRAM_WRITE,
      l2_one:       RST_L2_ONE,
      l2_two:       RST_L2_TWO,
      l2_three:     RST_L2_THREE,
      pci_one:      RST_PCI_ONE,
      pci_slot:     RST_PCI_SLOT,
      top_low:      RST_TOP_LOW,
      pci_two:      RST_PCI_TWO,
      ide_hw:       RST_IDE_HW,
      ide_setup:    {4{RST_IDE_TIME}},
      ide_recovery: {4{RST_IDE_TIME}},
      rdata:        8'h00,
      prescale:     4'h0,
      slot_left:    8'h00,
      slot_expired: 1'b0,
      req_meta:     1'b1,
      req_sync:     1'b1
   };

endpackage

// ---- hw/clcr_regs.sv ----
// Operation
// [RULE1] EDO read CAS code n gives n+1 clocks
// [RULE2] Refresh pin and EDO probe test bits
// [RULE3] Master read extra wait when bit set
// [RULE4] Master and host write lag one clock
// [RULE5] Write ready point two-bit mode field
// [RULE6] EDO output-disable pulse one or half clock
// [RULE7] Write CAS code gives one to four clocks
// [RULE8] Cache size and cache mode fields
// [RULE9] Hit check point, hit wait, copy-back setup
// [RULE10] Burst read and write rate select bits
// [RULE11] Tag layout and burst order bits
// [RULE12] CPU pin meaning, shadow caching, vendor burst
// [RULE13] Initialize fill and burst fill policies
// [RULE14] SRAM type, master wait, tag delay
// [RULE15] Active-low PCI enables, L1 write-back flag
// [RULE16] Master slot timer removes grant at expiry
// [RULE17] Top of memory in 64K units
// [RULE18] Parity enable and strobe timing bits
// [RULE19] IDE command release two or three clocks
// [RULE20] IDE port swap and decode disables
// [RULE21] Per-command prefetch disables, primary master only
// [RULE22] IDE setup and recovery, zero means sixteen
// [RULE23] Software uses index then data port
// [RULE24] Reserved bits and indices read zero
// [RULE25] Reset restores all default field values
`timescale 1ns/1ps
module clcr_regs
(
   input  wire logic                clock,
   input  wire logic                rst,
   input  wire logic [15:0]         io_addr,
   input  wire logic                io_wr,
   input  wire logic                io_rd,
   input  wire logic [7:0]          io_wdata,
   output logic [7:0]               io_rdata,
   input  wire logic                pci_req_n,
   output logic                     pci_gnt_remove,
   output logic [3:0]               edo_rd_cas_width,
   output logic                     refresh_test_sel,
   output logic                     edo_probe_mode,
   output logic                     master_read_extra_wait,
   output logic                     master_write_lag,
   output logic                     host_write_lag,
   output logic [1:0]               write_ready_point,
   output logic                     edo_oe_pulse,
   output logic [2:0]               wr_cas_width,
   output logic [10:0]              l2_size_kb,
   output logic [1:0]               l2_op_mode,
   output logic [1:0]               hit_check_time,
   output logic                     hit_wait_sel,
   output logic                     copyback_setup,
   output logic                     burst_rd_rate,
   output logic                     burst_wr_rate,
   output logic                     tag_layout_opt,
   output logic                     burst_linear,
   output logic                     page_cache_disable_pin,
   output logic                     shadow_l2_cacheable,
   output logic                     init_fill_policy,
   output logic                     burst_fill_policy,
   output logic                     l2_sram_type,
   output logic                     master_rd_l2_wait,
   output logic                     tag_write_delay,
   output logic                     vendor_wb_burst,
   output logic                     h2p_b2b_dis,
   output logic                     h2p_merge_dis,
   output logic                     h2p_burst_dis,
   output logic                     h2p_post_dis,
   output logic                     p2h_burst_dis,
   output logic                     l1_writeback_cpu,
   output logic [12:0]              top_mem_units,
   output logic                     pci_parity_en,
   output logic                     master_strobe_timing,
   output logic                     ide_prefetch_en,
   output logic [1:0]               ide_cmd_off_clks,
   output logic                     ide_port1_decode_en,
   output logic                     ide_port2_decode_en,
   output logic                     ide_port1_secondary,
   output logic                     ide_wide_mode,
   output logic                     ide_posted_wr,
   output logic [2:0]               ide_cmd_prefetch_dis,
   output logic [3:0][4:0]          ide_setup_clks,
   output logic [3:0][4:0]          ide_rd_recovery_clks,
   output logic [3:0][4:0]          ide_wr_recovery_clks
);
   import clcr_pkg::*;

   clcr_state_t state_ff;    // All registered state
   clcr_state_t nxt_state;   // Next value of the state
   logic        index_hit;   // Index port addressed
   logic        data_hit;    // Data port addressed
   logic        slot_tick;   // Slot timer step
   logic [7:0]  read_value;  // Register selected by index

   // Four-bit IDE code to clock count
   function automatic logic [4:0] ide_clks(input logic [3:0] code);
      ide_clks = (code == 4'h0) ? IDE_CODE_ZERO_CLKS : {1'b0, code};   // [RULE22]
   endfunction

   // Port decode of the I/O pair
   assign index_hit = (io_addr == IO_INDEX_PORT);   // [RULE23]
   assign data_hit  = (io_addr == IO_DATA_PORT);    // [RULE23]

   // Slot timer steps every 16 clocks, or every clock when bypassed
   assign slot_tick = !state_ff.pci_two[5] || (state_ff.prescale == SLOT_PRESCALE_LAST);

   // Read multiplexer over the index
   always_comb
   begin
      read_value = 8'h00;   // Unmapped indices read zero [RULE24]
      unique case (state_ff.index)
         IDX_DRAM_CAS:   read_value = state_ff.dram_cas;
         IDX_DRAM_WRITE: read_value = state_ff.dram_write;
         IDX_L2_ONE:     read_value = state_ff.l2_one;
         IDX_L2_TWO:     read_value = state_ff.l2_two;
         IDX_L2_THREE:   read_value = state_ff.l2_three;
         IDX_PCI_ONE:    read_value = state_ff.pci_one;
         IDX_PCI_SLOT:   read_value = state_ff.pci_slot;
         IDX_TOP_LOW:    read_value = state_ff.top_low;
         IDX_PCI_TWO:    read_value = state_ff.pci_two;
         IDX_IDE_HW:     read_value = state_ff.ide_hw;
         default:        read_value = 8'h00;
      endcase
      for (int i = 0; i < 4; i++)
      begin
         if (state_ff.index == IDX_IDE_SETUP[i])
         begin
            read_value = state_ff.ide_setup[i];
         end
         if (state_ff.index == IDX_IDE_RECOVERY[i])
         begin
            read_value = state_ff.ide_recovery[i];
         end
      end
   end

   // Next-state logic
   always_comb
   begin
      nxt_state = state_ff;
      // Request pin synchroniser
      nxt_state.req_meta = pci_req_n;
      nxt_state.req_sync = state_ff.req_meta;
      // Index port write
      if (io_wr && index_hit)
      begin
         nxt_state.index = io_wdata;   // [RULE23]
      end
      // Data port write, reserved bits masked off
      if (io_wr && data_hit)
      begin
         unique case (state_ff.index)
            IDX_DRAM_CAS:   nxt_state.dram_cas   = io_wdata & MASK_DRAM_CAS;    // [RULE1] [RULE2]
            IDX_DRAM_WRITE: nxt_state.dram_write = io_wdata & MASK_DRAM_WRITE;  // [RULE3] [RULE4]
            IDX_L2_ONE:     nxt_state.l2_one     = io_wdata & MASK_L2_ONE;      // [RULE8] [RULE9]
            IDX_L2_TWO:     nxt_state.l2_two     = io_wdata & MASK_L2_TWO;      // [RULE10] [RULE11]
            IDX_L2_THREE:   nxt_state.l2_three   = io_wdata & MASK_L2_THREE;    // [RULE14] [RULE24]
            IDX_PCI_ONE:    nxt_state.pci_one    = io_wdata & MASK_PCI_ONE;     // [RULE15] [RULE24]
            IDX_PCI_SLOT:   nxt_state.pci_slot   = io_wdata & MASK_PCI_SLOT;    // [RULE16]
            IDX_TOP_LOW:    nxt_state.top_low    = io_wdata & MASK_TOP_LOW;     // [RULE17]
            IDX_PCI_TWO:    nxt_state.pci_two    = io_wdata & MASK_PCI_TWO;     // [RULE17] [RULE18]
            IDX_IDE_HW:     nxt_state.ide_hw     = io_wdata & MASK_IDE_HW;      // [RULE19] [RULE20]
            default:        nxt_state.index      = state_ff.index;              // Ignored [RULE24]
         endcase
         for (int i = 0; i < 4; i++)
         begin
            if (state_ff.index == IDX_IDE_SETUP[i])
            begin
               // Command prefetch bits exist on the primary master only
               nxt_state.ide_setup[i] = io_wdata & ((i == 0) ? MASK_SETUP_PM : MASK_SETUP); // [RULE21]
            end
            if (state_ff.index == IDX_IDE_RECOVERY[i])
            begin
               nxt_state.ide_recovery[i] = io_wdata & MASK_RECOVERY;   // [RULE22]
            end
         end
      end
      // Read data captured on the read strobe
      if (io_rd && index_hit)
      begin
         nxt_state.rdata = state_ff.index;
      end
      else if (io_rd && data_hit)
      begin
         nxt_state.rdata = read_value;
      end
      // Master slot timer
      if (state_ff.req_sync || (state_ff.pci_slot == 8'h00))
      begin
         // Reload while request idle, hold off when disabled
         nxt_state.prescale     = 4'h0;                 // [RULE16]
         nxt_state.slot_left    = state_ff.pci_slot;    // [RULE16]
         nxt_state.slot_expired = 1'b0;
      end
      else if (!state_ff.slot_expired)
      begin
         nxt_state.prescale = state_ff.prescale + 4'h1;
         if (slot_tick)
         begin
            // Value X runs X+1 steps
            if (state_ff.slot_left == 8'h00)
            begin
               nxt_state.slot_expired = 1'b1;          // [RULE16]
            end
            else
            begin
               nxt_state.slot_left = state_ff.slot_left - 8'h01;
            end
         end
      end
   end

   // State register, defaults while reset is high
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state_ff <= CLCR_STATE_RST;   // [RULE25]
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // Read data and grant removal
   assign io_rdata       = state_ff.rdata;
   assign pci_gnt_remove = state_ff.slot_expired;   // [RULE16]

   // DRAM timing fields
   assign edo_rd_cas_width       = {1'b0, state_ff.dram_cas[4:2]} + 4'h1;   // [RULE1]
   assign refresh_test_sel       = state_ff.dram_cas[1];                    // [RULE2]
   assign edo_probe_mode         = state_ff.dram_cas[0];                    // [RULE2]
   assign master_read_extra_wait = state_ff.dram_write[7];                  // [RULE3]
   assign master_write_lag       = state_ff.dram_write[6];                  // [RULE4]
   assign host_write_lag         = state_ff.dram_write[5];                  // [RULE4]
   assign write_ready_point      = state_ff.dram_write[4:3];                // [RULE5]
   assign edo_oe_pulse           = state_ff.dram_write[2];                  // [RULE6]
   assign wr_cas_width           = {1'b0, state_ff.dram_write[1:0]} + 3'h1; // [RULE7]

   // Level 2 cache fields
   assign l2_size_kb             = L2_SIZE_BASE_KB << state_ff.l2_one[7:6]; // [RULE8]
   assign l2_op_mode             = state_ff.l2_one[5:4];                    // [RULE8]
   assign hit_check_time         = state_ff.l2_one[3:2];                    // [RULE9]
   assign hit_wait_sel           = state_ff.l2_one[1];                      // [RULE9]
   assign copyback_setup         = state_ff.l2_one[0];                      // [RULE9]
   assign burst_rd_rate          = state_ff.l2_two[7];                      // [RULE10]
   assign burst_wr_rate          = state_ff.l2_two[6];                      // [RULE10]
   assign tag_layout_opt         = state_ff.l2_two[5];                      // [RULE11]
   assign burst_linear           = state_ff.l2_two[4];                      // [RULE11]
   assign page_cache_disable_pin = state_ff.l2_two[3];                      // [RULE12]
   assign shadow_l2_cacheable    = state_ff.l2_two[2];                      // [RULE12]
   assign init_fill_policy       = state_ff.l2_two[1];                      // [RULE13]
   assign burst_fill_policy      = state_ff.l2_two[0];                      // [RULE13]
   assign l2_sram_type           = state_ff.l2_three[7];                    // [RULE14]
   assign master_rd_l2_wait      = state_ff.l2_three[6];                    // [RULE14]
   assign tag_write_delay        = state_ff.l2_three[5];                    // [RULE14]
   assign vendor_wb_burst        = state_ff.l2_three[0];                    // [RULE12]

   // PCI host fields, disables are active high here
   assign h2p_b2b_dis            = state_ff.pci_one[7];                     // [RULE15]
   assign h2p_merge_dis          = state_ff.pci_one[6];                     // [RULE15]
   assign h2p_burst_dis          = state_ff.pci_one[5];                     // [RULE15]
   assign h2p_post_dis           = state_ff.pci_one[4];                     // [RULE15]
   assign p2h_burst_dis          = state_ff.pci_one[3];                     // [RULE15]
   assign l1_writeback_cpu       = state_ff.pci_one[2];                     // [RULE15]
   assign top_mem_units          = {state_ff.pci_two[4:0], state_ff.top_low}; // [RULE17]
   assign pci_parity_en          = state_ff.pci_two[7];                     // [RULE18]
   assign master_strobe_timing   = state_ff.pci_two[6];                     // [RULE18]

   // IDE global fields
   assign ide_prefetch_en        = state_ff.ide_hw[7];                      // [RULE19]
   assign ide_cmd_off_clks       = state_ff.ide_hw[6] ? IDE_CMD_OFF_LONG : IDE_CMD_OFF_SHORT; // [RULE19]
   assign ide_port1_secondary    = state_ff.ide_hw[5];                      // [RULE20]
   assign ide_port1_decode_en    = state_ff.ide_hw[5] ? !state_ff.ide_hw[4] : !state_ff.ide_hw[3]; // [RULE20]
   assign ide_port2_decode_en    = state_ff.ide_hw[5] ? !state_ff.ide_hw[3] : !state_ff.ide_hw[4]; // [RULE20]
   assign ide_wide_mode          = state_ff.ide_hw[2];                      // [RULE19]
   assign ide_posted_wr          = state_ff.ide_hw[1];                      // [RULE19]
   assign ide_cmd_prefetch_dis   = state_ff.ide_setup[0][7:5];              // [RULE21]

   // Per-drive IDE timing counts
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         ide_setup_clks[i]       = ide_clks(state_ff.ide_setup[i][3:0]);    // [RULE22]
         ide_rd_recovery_clks[i] = ide_clks(state_ff.ide_recovery[i][3:0]); // [RULE22]
         ide_wr_recovery_clks[i] = ide_clks(state_ff.ide_recovery[i][7:4]); // [RULE22]
      end
   end

   // Checks
   a_extra_wait_write: assert property (@(posedge clock) disable iff (rst) // [RULE3]
      (io_wr && data_hit && state_ff.index == IDX_DRAM_WRITE)
      |=> (master_read_extra_wait == $past(io_wdata[7])))
      else $error("extra wait bit not taken from write");

   a_reserved_index_zero: assert property (@(posedge clock) disable iff (rst) // [RULE24]
      (io_rd && data_hit && state_ff.index == 8'h13) |=> (io_rdata == 8'h00))
      else $error("reserved index did not read zero");

   a_l2_unused_zero: assert property (@(posedge clock) disable iff (rst) // [RULE24]
      (io_rd && data_hit && state_ff.index == IDX_L2_THREE) |=> (io_rdata[4:1] == 4'h0))
      else $error("unused cache control bits not zero");

   a_setup_zero_sixteen: assert property (@(posedge clock) disable iff (rst) // [RULE22]
      (io_wr && data_hit && state_ff.index == IDX_IDE_SETUP[3] && io_wdata[3:0] == 4'h0)
      |=> (ide_setup_clks[3] == 5'h10))
      else $error("setup code zero not sixteen clocks");

   a_prefetch_pm_only: assert property (@(posedge clock) disable iff (rst) // [RULE21]
      (io_wr && data_hit && state_ff.index == IDX_IDE_SETUP[1])
      |=> $stable(ide_cmd_prefetch_dis) && (state_ff.ide_setup[1][7:4] == 4'h0))
      else $error("prefetch bits changed by other drive");

   a_slot_reload_idle: assert property (@(posedge clock) disable iff (rst) // [RULE16]
      state_ff.req_sync |=> !pci_gnt_remove)
      else $error("grant removal while request idle");

   a_slot_zero_off: assert property (@(posedge clock) disable iff (rst) // [RULE16]
      (state_ff.pci_slot == 8'h00) [*2] |-> !pci_gnt_remove)
      else $error("disabled slot timer expired");

   a_slot_bypass_len: assert property (@(posedge clock) disable iff (rst) // [RULE16]
      ($fell(state_ff.req_sync) && !state_ff.pci_two[5] && state_ff.pci_slot == 8'h01
       && $stable(state_ff.pci_two) && $stable(state_ff.pci_slot))
      ##1 (!state_ff.req_sync && !pci_gnt_remove) |=> pci_gnt_remove)
      else $error("bypassed slot of two ticks wrong length");

   a_cmd_off_clks: assert property (@(posedge clock) disable iff (rst) // [RULE19]
      (io_wr && data_hit && state_ff.index == IDX_IDE_HW)
      |=> (ide_cmd_off_clks == ($past(io_wdata[6]) ? 2'h3 : 2'h2)))
      else $error("command release count wrong");

   a_top_mem_join: assert property (@(posedge clock) disable iff (rst) // [RULE17]
      (io_wr && data_hit && state_ff.index == IDX_PCI_TWO)
      |=> (top_mem_units[12:8] == $past(io_wdata[4:0])))
      else $error("top of memory high bits wrong");

endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
   $display("Error at %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
   import clcr_pkg::*;
   // Stimulus and readback
   logic            clock = 1'b0, rst = 1'b1, io_wr = 1'b0, io_rd = 1'b0, pci_req_n = 1'b1;
   logic [15:0]     io_addr = 16'h0000;
   logic [7:0]      io_wdata = 8'h00, io_rdata, rv;
   // Decoded outputs
   logic pci_gnt_remove, refresh_test_sel, edo_probe_mode, master_read_extra_wait;
   logic master_write_lag, host_write_lag, edo_oe_pulse, hit_wait_sel, copyback_setup;
   logic burst_rd_rate, burst_wr_rate, tag_layout_opt, burst_linear, page_cache_disable_pin;
   logic shadow_l2_cacheable, init_fill_policy, burst_fill_policy, l2_sram_type;
   logic master_rd_l2_wait, tag_write_delay, vendor_wb_burst, h2p_b2b_dis, h2p_merge_dis;
   logic h2p_burst_dis, h2p_post_dis, p2h_burst_dis, l1_writeback_cpu, pci_parity_en;
   logic master_strobe_timing, ide_prefetch_en, ide_port1_decode_en, ide_port2_decode_en;
   logic ide_port1_secondary, ide_wide_mode, ide_posted_wr;
   logic [1:0]      write_ready_point, l2_op_mode, hit_check_time, ide_cmd_off_clks;
   logic [2:0]      wr_cas_width, ide_cmd_prefetch_dis;
   logic [3:0]      edo_rd_cas_width;
   logic [10:0]     l2_size_kb;
   logic [12:0]     top_mem_units;
   logic [3:0][4:0] ide_setup_clks, ide_rd_recovery_clks, ide_wr_recovery_clks;
   int              err_count = 0, total_checks = 0, n1, n3, np;
   // Indices, reset values, writable masks
   localparam logic [7:0] IDX [18] = '{8'h0c, 8'h0d, 8'h10, 8'h11, 8'h12, 8'h20, 8'h21, 8'h22,
      8'h23, 8'h60, 8'h61, 8'h62, 8'h66, 8'h67, 8'h6b, 8'h6c, 8'h70, 8'h71};
   localparam logic [7:0] DEF [18] = '{8'hfc, 8'he3, 8'h00, 8'h00, 8'h00, 8'hfc, 8'h00, 8'h00,
      8'he0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] MSK [18] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'he1, 8'hfc, 8'hff, 8'hff,
      8'hff, 8'hfe, 8'hef, 8'hff, 8'h0f, 8'hff, 8'h0f, 8'hff, 8'h0f, 8'hff};
   // Single-bit fields except grant removal and the two IDE port decode enables, in one vector
   wire [31:0] flags = {refresh_test_sel, edo_probe_mode, master_read_extra_wait,
      master_write_lag, host_write_lag, edo_oe_pulse, hit_wait_sel, copyback_setup,
      burst_rd_rate, burst_wr_rate, tag_layout_opt, burst_linear, page_cache_disable_pin,
      shadow_l2_cacheable, init_fill_policy, burst_fill_policy, l2_sram_type,
      master_rd_l2_wait, tag_write_delay, vendor_wb_burst, h2p_b2b_dis, h2p_merge_dis,
      h2p_burst_dis, h2p_post_dis, p2h_burst_dis, l1_writeback_cpu, pci_parity_en,
      master_strobe_timing, ide_prefetch_en, ide_port1_secondary, ide_wide_mode, ide_posted_wr};
   clcr_regs dut_u (.*);
   // Host clock
   always #2.5 clock = ~clock;
   // Verdict and end of run
   task automatic conclude;
      if (err_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // One I/O write strobe
   task automatic put(input logic [15:0] a, input logic [7:0] d);
      @(negedge clock);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge clock);
      io_wr = 1'b0;
   endtask
   // Index then data write
   task automatic wreg(input logic [7:0] i, input logic [7:0] d);
      put(IO_INDEX_PORT, i);
      put(IO_DATA_PORT, d);
   endtask
   // Index write then data read
   task automatic rreg(input logic [7:0] i, output logic [7:0] d);
      put(IO_INDEX_PORT, i);
      io_addr = IO_DATA_PORT;
      io_rd = 1'b1;
      @(negedge clock);
      io_rd = 1'b0;
      @(negedge clock);
      d = io_rdata;
   endtask
   // Optionally write v to each place and read it straight back
   task automatic sweep(input logic wr, input logic [7:0] v);
      for (int k = 0; k < 18; k++)
      begin
         if (wr)
            wreg(IDX[k], v);
         rreg(IDX[k], rv);
         `CHK(rv, wr ? v & MSK[k] : DEF[k])
      end
      wreg(8'h13, v);
      rreg(8'h13, rv);
      `CHK(rv, 8'h00)
   endtask
   // Default state at the field outputs
   task automatic dflt;
      sweep(1'b0, 8'h00);
      `CHK({edo_rd_cas_width, wr_cas_width}, 7'h44)
      `CHK(flags, 32'h38000ff0)
      `CHK({ide_setup_clks, ide_rd_recovery_clks}, {8{5'h10}})
   endtask
   // Field decode after all ones or all zeros
   task automatic outs(input logic h);
      `CHK(flags, {32{h}})
      `CHK({edo_rd_cas_width, wr_cas_width}, h ? 7'h44 : 7'h09)
      `CHK({write_ready_point, l2_op_mode, hit_check_time}, {6{h}})
      `CHK(l2_size_kb, h ? 11'h400 : 11'h080)
      `CHK(top_mem_units, {13{h}})
      `CHK({ide_port1_decode_en, ide_port2_decode_en, ide_cmd_off_clks}, h ? 4'h3 : 4'he)
      `CHK(ide_cmd_prefetch_dis, {3{h}})
      `CHK({ide_setup_clks, ide_wr_recovery_clks}, {8{h ? 5'h0f : 5'h10}})
      `CHK(ide_rd_recovery_clks, {4{h ? 5'h0f : 5'h10}})
   endtask
   // Cycles from request to grant removal
   task automatic slot_wait(input logic [7:0] ctl, input logic [7:0] slot, output int n);
      wreg(IDX_PCI_TWO, ctl);
      wreg(IDX_PCI_SLOT, slot);
      pci_req_n = 1'b0;
      n = 0;
      while (pci_gnt_remove !== 1'b1 && n < 200)
      begin
         @(negedge clock);
         n++;
      end
      if (n == 200)
      begin
         err_count++;
         conclude();
      end
      pci_req_n = 1'b1;
      repeat (4) @(negedge clock);
      `CHK(pci_gnt_remove, 1'b0)
   endtask
   // Main sequence
   initial
   begin
      repeat (4) @(negedge clock);
      rst = 1'b0;
      dflt();
      sweep(1'b1, 8'hff);
      outs(1'b1);
      rst = 1'b1;
      @(negedge clock);
      rst = 1'b0;
      dflt();
      sweep(1'b1, 8'h00);
      outs(1'b0);
      pci_req_n = 1'b0;
      repeat (40) @(negedge clock);
      `CHK(pci_gnt_remove, 1'b0)
      pci_req_n = 1'b1;
      slot_wait(8'h00, 8'h01, n1);
      slot_wait(8'h00, 8'h03, n3);
      slot_wait(8'h20, 8'h01, np);
      `CHK(n3 - n1, 2)
      `CHK(np - n1, 30)
      conclude();
   end
endmodule
